// File: rtl/radio_cfg_regs.sv
// Purpose: power, slow clock and synthesizer configuration register bank
// Assumes: host frame = header byte, address byte, then data bytes
// Notes: address advances after each data byte; unmapped reads give zero
`timescale 1ns/100ps
`default_nettype none
module radio_cfg_regs
	import radio_cfg_pkg::*;
#(
	parameter int CARRIER_WIDTH = 32,
	parameter logic [31:0] BASE_FREQ = 32'h0000_0000,
	parameter logic [15:0] CHANNEL_SPACING = 16'h0001
)
(
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// serial host port
	input wire logic I_CS_N,
	input wire logic I_SCLK,
	input wire logic I_MOSI,
	output logic O_MISO,
	// slow clock sources and operating mode
	input wire logic I_SLOW_RC_CLK,
	input wire logic I_GPIO_SLOW_CLK,
	input wire logic I_TX_MODE,
	// switching regulator controls
	output logic O_REGULATOR_SWITCH_CLK,
	output logic O_RATE_MULTIPLIER_ON,
	output logic O_REGULATOR_ON,
	output logic O_REGULATOR_TUNE_VOLTAGE,
	output logic O_REGULATOR_LOOP_BANDWIDTH,
	output logic O_TEMP_SENSE_BUFFER_ON,
	// slow clock
	output logic O_EXTERNAL_SLOW_CLOCK,
	output logic O_SLOW_CLK,
	output logic [3:0] O_SLOW_OSC_TRIM_A,
	output logic [4:0] O_SLOW_OSC_TRIM_B,
	// synthesizer
	output logic [7:0] O_CHANNEL_INDEX,
	output logic [CARRIER_WIDTH-1:0] O_CARRIER_WORD,
	output logic [5:0] O_OSCILLATOR_BIAS_CURRENT,
	output logic [6:0] O_TRANSMIT_OSC_CAL_WORD,
	output logic O_TRANSMIT_OSC_CAL_APPLY
);

	// refuse carrier widths that the sum cannot serve
	if (CARRIER_WIDTH < 24 || CARRIER_WIDTH > 32)
	begin : g_bad_width
		$error("CARRIER_WIDTH must lie between 24 and 32");
	end

	// ----------------------------------------------------------------
	// serial shifter
	// ----------------------------------------------------------------
	host_byte_if hb ();

	host_shifter u_shifter
	(
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.i_cs_n(I_CS_N),
		.i_sclk(I_SCLK),
		.i_mosi(I_MOSI),
		.o_miso(O_MISO),
		.bus(hb.shifter)
	);

	// ----------------------------------------------------------------
	// host frame sequencing
	// ----------------------------------------------------------------
	host_state_t state_ff;
	host_state_t nxt_state;
	logic [7:0] addr_ff;
	logic [7:0] regs_ff [REG_COUNT];
	logic [REG_COUNT-1:0] hit_wr;
	logic wr_en;

	// next state of the frame decoder
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_HEADER:
				if (hb.byte_done)
					nxt_state = (hb.rx_byte == HDR_WRITE) ? ST_ADDR :
						(hb.rx_byte == HDR_READ) ? ST_ADDR : ST_IGNORE;
			ST_ADDR:
				;
			ST_WRITE:
				;
			ST_READ:
				;
			ST_IGNORE:
				;
			default:
				nxt_state = ST_HEADER;
		endcase
	end

	// frame state and direction; a frame ends when chip select rises
	logic is_read_ff;
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			state_ff <= ST_HEADER;
			is_read_ff <= 1'b0;
		end
		else if (!hb.frame_active)
			state_ff <= ST_HEADER;
		else if (hb.byte_done)
		begin
			if (state_ff == ST_HEADER)
			begin
				state_ff <= nxt_state;
				is_read_ff <= (hb.rx_byte == HDR_READ);
			end
			else if (state_ff == ST_ADDR)
				state_ff <= is_read_ff ? ST_READ : ST_WRITE;
		end
	end

	// address pointer, advanced after every data byte
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			addr_ff <= 8'h00;
		else if (hb.byte_done && state_ff == ST_ADDR)
			addr_ff <= hb.rx_byte;
		else if (hb.byte_done && (state_ff == ST_WRITE || state_ff == ST_READ))
			addr_ff <= addr_ff + 8'h01;
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	assign wr_en = hb.byte_done && state_ff == ST_WRITE;

	// one byte register per mapped offset, reserved bits stored as written
	genvar g;
	generate
		for (g = 0; g < REG_COUNT; g++)
		begin : g_reg
			assign hit_wr[g] = wr_en && (addr_ff == REG_ADDR[g]);
			always_ff @(posedge I_CLK_SYS or posedge I_RST)
			begin
				if (I_RST)
					regs_ff[g] <= REG_RESET[g];
				else if (hit_wr[g])
					regs_ff[g] <= hb.rx_byte;
			end
		end
	endgenerate

	// read mux; unmapped offsets read as zero
	function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] r [REG_COUNT]);
		logic [7:0] v;
		v = UNMAPPED_READ;
		for (int i = 0; i < REG_COUNT; i++)
		begin
			if (a == REG_ADDR[i])
				v = r[i];
		end
		return v;
	endfunction

	// byte loaded for the next outgoing slot
	always_comb
	begin
		if (state_ff == ST_ADDR)
			hb.tx_byte = read_reg(hb.rx_byte, regs_ff);
		else if (state_ff == ST_READ)
			hb.tx_byte = read_reg(addr_ff + 8'h01, regs_ff);
		else
			hb.tx_byte = 8'h00;
	end

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	logic [RATIO_WIDTH-1:0] ratio;
	assign ratio = {regs_ff[IDX_RATIO_HIGH][6:0], regs_ff[IDX_RATIO_LOW]};

	// static controls, registered from the bank
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_REGULATOR_ON <= 1'b1;
			O_REGULATOR_TUNE_VOLTAGE <= 1'b1;
			O_REGULATOR_LOOP_BANDWIDTH <= 1'b1;
			O_TEMP_SENSE_BUFFER_ON <= 1'b0;
			O_RATE_MULTIPLIER_ON <= 1'b0;
			O_EXTERNAL_SLOW_CLOCK <= 1'b0;
			O_SLOW_OSC_TRIM_A <= 4'h7;
			O_SLOW_OSC_TRIM_B <= 5'h00;
			O_CHANNEL_INDEX <= 8'h00;
			O_OSCILLATOR_BIAS_CURRENT <= 6'h11;
		end
		else
		begin
			O_REGULATOR_ON <= !regs_ff[IDX_REG_CONTROL][REG_OFF_BIT];
			O_REGULATOR_TUNE_VOLTAGE <= regs_ff[IDX_REG_CONTROL][TUNE_VOLT_BIT];
			O_REGULATOR_LOOP_BANDWIDTH <= regs_ff[IDX_REG_CONTROL][LOOP_BW_BIT];
			O_TEMP_SENSE_BUFFER_ON <= regs_ff[IDX_REG_CONTROL][TS_BUFFER_BIT];
			O_RATE_MULTIPLIER_ON <= regs_ff[IDX_RATIO_HIGH][RATE_MULT_ON_BIT];
			O_EXTERNAL_SLOW_CLOCK <= regs_ff[IDX_SLOW_CLK_SRC][EXT_SLOW_CLK_BIT];
			O_SLOW_OSC_TRIM_A <= regs_ff[IDX_TRIM_HIGH][7:4];
			O_SLOW_OSC_TRIM_B <= {regs_ff[IDX_TRIM_HIGH][3:0], regs_ff[IDX_TRIM_LOW_TX][TRIM_B_LSB_BIT]};
			O_CHANNEL_INDEX <= regs_ff[IDX_CHANNEL_INDEX];
			O_OSCILLATOR_BIAS_CURRENT <= regs_ff[IDX_OSC_CURRENT][5:0];
		end
	end

	// transmit calibration word, presented only in transmit mode
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			O_TRANSMIT_OSC_CAL_WORD <= 7'h00;
			O_TRANSMIT_OSC_CAL_APPLY <= 1'b0;
		end
		else
		begin
			O_TRANSMIT_OSC_CAL_WORD <= I_TX_MODE ? regs_ff[IDX_TRIM_LOW_TX][6:0] : 7'h00;
			O_TRANSMIT_OSC_CAL_APPLY <= I_TX_MODE;
		end
	end

	// carrier word: base plus channel times spacing
	logic [31:0] carrier_sum;
	// widen before the product so channel times spacing keeps all 24 bits
	assign carrier_sum = BASE_FREQ + 32'(regs_ff[IDX_CHANNEL_INDEX]) * 32'(CHANNEL_SPACING);
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			O_CARRIER_WORD <= '0;
		else
			O_CARRIER_WORD <= carrier_sum[CARRIER_WIDTH-1:0];
	end

	// slow clock source; the selected pin is sampled, not gated
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			O_SLOW_CLK <= 1'b0;
		else
			O_SLOW_CLK <= regs_ff[IDX_SLOW_CLK_SRC][EXT_SLOW_CLK_BIT] ? I_GPIO_SLOW_CLK : I_SLOW_RC_CLK;
	end

	// ----------------------------------------------------------------
	// regulator switching clock
	// ----------------------------------------------------------------
	logic [FIXED_DIV_WIDTH-1:0] div_ff;
	logic [RATIO_WIDTH-1:0] acc_ff;

	// fixed divider and phase accumulator both run from the system clock
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
		begin
			div_ff <= '0;
			acc_ff <= '0;
		end
		else
		begin
			div_ff <= div_ff + FIXED_DIV_WIDTH'(1);
			acc_ff <= acc_ff + ratio;
		end
	end

	// divide by four, or accumulator msb at ratio over two to fifteen
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
	begin
		if (I_RST)
			O_REGULATOR_SWITCH_CLK <= 1'b0;
		else if (regs_ff[IDX_RATIO_HIGH][RATE_MULT_ON_BIT])
			O_REGULATOR_SWITCH_CLK <= acc_ff[RATIO_WIDTH-1];
		else
			O_REGULATOR_SWITCH_CLK <= div_ff[FIXED_DIV_WIDTH-1];
	end

endmodule
`default_nettype wire

// File: rtl/radio_cfg_pkg.sv
// Purpose: shared constants for the radio configuration register bank
// Assumes: byte-wide registers reached over the serial host port
// Notes: offsets are the printed byte addresses of the host port
package radio_cfg_pkg;

	// ----------------------------------------------------------------
	// host port framing
	// ----------------------------------------------------------------
	localparam logic [7:0] HDR_WRITE = 8'h00;
	localparam logic [7:0] HDR_READ = 8'h01;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam int REG_COUNT = 10;
	localparam logic [7:0] ADDR_CHANNEL_INDEX = 8'h6C;
	localparam logic [7:0] ADDR_SLOW_OSC_TRIM_HIGH = 8'h6D;
	localparam logic [7:0] ADDR_SLOW_OSC_TRIM_LOW_TX_VCO_WORD = 8'h6E;
	localparam logic [7:0] ADDR_OSCILLATOR_CURRENT_CFG = 8'hA1;
	localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'hA4;
	localparam logic [7:0] ADDR_SWITCH_CLOCK_RATIO_HIGH = 8'hA5;
	localparam logic [7:0] ADDR_SWITCH_CLOCK_RATIO_LOW = 8'hA6;
	localparam logic [7:0] ADDR_SLOW_CLOCK_SOURCE_CFG = 8'hA7;
	localparam logic [7:0] ADDR_TEST_SELECTION = 8'hA8;
	localparam logic [7:0] ADDR_POWER_TEST = 8'hB2;

	// ----------------------------------------------------------------
	// register indices into the bank
	// ----------------------------------------------------------------
	localparam int IDX_CHANNEL_INDEX = 0;
	localparam int IDX_TRIM_HIGH = 1;
	localparam int IDX_TRIM_LOW_TX = 2;
	localparam int IDX_OSC_CURRENT = 3;
	localparam int IDX_REG_CONTROL = 4;
	localparam int IDX_RATIO_HIGH = 5;
	localparam int IDX_RATIO_LOW = 6;
	localparam int IDX_SLOW_CLK_SRC = 7;
	localparam int IDX_TEST_SEL = 8;
	localparam int IDX_POWER_TEST = 9;

	localparam logic [7:0] REG_ADDR [REG_COUNT] = '{
		ADDR_CHANNEL_INDEX, ADDR_SLOW_OSC_TRIM_HIGH, ADDR_SLOW_OSC_TRIM_LOW_TX_VCO_WORD,
		ADDR_OSCILLATOR_CURRENT_CFG, ADDR_REGULATOR_CONTROL, ADDR_SWITCH_CLOCK_RATIO_HIGH,
		ADDR_SWITCH_CLOCK_RATIO_LOW, ADDR_SLOW_CLOCK_SOURCE_CFG, ADDR_TEST_SELECTION,
		ADDR_POWER_TEST};

	// ----------------------------------------------------------------
	// reset values, whole bytes including reserved bits
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET [REG_COUNT] = '{
		8'h00, 8'h70, 8'h48, 8'h11, 8'h0C, 8'h20, 8'h00, 8'hE1, 8'h00, 8'h42};

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TS_BUFFER_BIT = 6;
	localparam int REG_OFF_BIT = 5;
	localparam int TUNE_VOLT_BIT = 3;
	localparam int LOOP_BW_BIT = 2;
	localparam int RATE_MULT_ON_BIT = 7;
	localparam int EXT_SLOW_CLK_BIT = 3;
	localparam int TRIM_B_LSB_BIT = 7;
	localparam int RATIO_WIDTH = 15;
	localparam int FIXED_DIV_WIDTH = 2;  // divide by 4

	// host port sequencing
	typedef enum {ST_HEADER, ST_ADDR, ST_WRITE, ST_READ, ST_IGNORE} host_state_t;

endpackage

// File: rtl/host_byte_if.sv
// Purpose: byte handshake between the serial shifter and the register bank
// Assumes: one clock domain, I_CLK_SYS
// Notes: byte_done is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface host_byte_if;
	logic frame_active;
	logic byte_done;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;

	modport shifter
	(
		output frame_active,
		output byte_done,
		output rx_byte,
		input tx_byte
	);
	modport bank
	(
		input frame_active,
		input byte_done,
		input rx_byte,
		output tx_byte
	);
endinterface
`default_nettype wire

// File: rtl/host_shifter.sv
// Purpose: serial host port shifter, mode 0, msb first
// Assumes: port pins are synchronous to I_CLK_SYS and far slower than it
// Notes: the next outgoing byte is loaded when an incoming byte completes
`timescale 1ns/100ps
`default_nettype none
module host_shifter
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// serial pins
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_mosi,
	output logic o_miso,
	// bank side
	host_byte_if.shifter bus
);

	logic sclk_prev_ff;
	logic [2:0] bit_cnt_ff;
	logic [6:0] rx_shift_ff;
	logic [7:0] tx_shift_ff;
	logic hold_ff;
	logic rise;
	logic fall;

	// edges of the serial clock, only inside a frame
	assign rise = !i_cs_n && i_sclk && !sclk_prev_ff;
	assign fall = !i_cs_n && !i_sclk && sclk_prev_ff;
	assign bus.frame_active = !i_cs_n;
	assign bus.byte_done = rise && (bit_cnt_ff == 3'h7);
	assign bus.rx_byte = {rx_shift_ff, i_mosi};
	assign o_miso = tx_shift_ff[7];

	// serial clock history
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			sclk_prev_ff <= 1'b0;
		else
			sclk_prev_ff <= i_sclk;
	end

	// incoming bits and bit count; only the count is cleared between frames
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			bit_cnt_ff <= 3'h0;
			rx_shift_ff <= 7'h00;
		end
		else if (i_cs_n)
			bit_cnt_ff <= 3'h0;
		else if (rise)
		begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			rx_shift_ff <= {rx_shift_ff[5:0], i_mosi};
		end
	end

	// outgoing bits; the fall right after a load keeps bit 7 on the pin
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tx_shift_ff <= 8'h00;
			hold_ff <= 1'b0;
		end
		else if (i_cs_n)
		begin
			tx_shift_ff <= 8'h00;
			hold_ff <= 1'b0;
		end
		else if (bus.byte_done)
		begin
			tx_shift_ff <= bus.tx_byte;
			hold_ff <= 1'b1;
		end
		else if (fall)
		begin
			if (hold_ff)
				hold_ff <= 1'b0;
			else
				tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
		end
	end

endmodule
`default_nettype wire

// File: verification/radio_cfg_regs_props.sv
// Purpose: port checks for the config register bank
// Assumes: one clock, async active high reset
// Notes: bound to every bank instance
`timescale 1ns/100ps
`default_nettype none
module radio_cfg_regs_props
#(
	parameter int CARRIER_WIDTH = 32,
	parameter logic [31:0] BASE_FREQ = 32'h0000_0000,
	parameter logic [15:0] CHANNEL_SPACING = 16'h0001
)
(
	// clock, reset, select
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic I_CS_N,
	// slow clocks and mode
	input wire logic I_SLOW_RC_CLK,
	input wire logic I_GPIO_SLOW_CLK,
	input wire logic I_TX_MODE,
	// watched outputs
	input wire logic O_REGULATOR_SWITCH_CLK,
	input wire logic O_RATE_MULTIPLIER_ON,
	input wire logic O_REGULATOR_ON,
	input wire logic O_REGULATOR_TUNE_VOLTAGE,
	input wire logic O_REGULATOR_LOOP_BANDWIDTH,
	input wire logic O_EXTERNAL_SLOW_CLOCK,
	input wire logic O_SLOW_CLK,
	input wire logic [3:0] O_SLOW_OSC_TRIM_A,
	input wire logic [7:0] O_CHANNEL_INDEX,
	input wire logic [CARRIER_WIDTH-1:0] O_CARRIER_WORD,
	input wire logic [5:0] O_OSCILLATOR_BIAS_CURRENT,
	input wire logic [6:0] O_TRANSMIT_OSC_CAL_WORD,
	input wire logic O_TRANSMIT_OSC_CAL_APPLY
);
	logic [2:0] up_ff; // edges since reset release
	logic [2:0] div_ff; // edges with the divider path chosen

	// saturating count of edges after reset
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
		if (I_RST)
			up_ff <= 3'h0;
		else if (up_ff != 3'h7)
			up_ff <= up_ff + 3'h1;

	// saturating count of edges with the multiplier off
	always_ff @(posedge I_CLK_SYS or posedge I_RST)
		if (I_RST)
			div_ff <= 3'h0;
		else if (O_RATE_MULTIPLIER_ON)
			div_ff <= 3'h0;
		else if (div_ff != 3'h7)
			div_ff <= div_ff + 3'h1;

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);

	// settled source selections and an idle host port
	sequence s_gpio_sel;
		O_EXTERNAL_SLOW_CLOCK [*3];
	endsequence
	sequence s_rc_sel;
		!O_EXTERNAL_SLOW_CLOCK [*3];
	endsequence
	sequence s_quiet;
		I_CS_N [*6];
	endsequence

	a_reset_decode: assert property (up_ff == 3'h0 |-> O_REGULATOR_ON && O_REGULATOR_TUNE_VOLTAGE
		&& O_REGULATOR_LOOP_BANDWIDTH && O_SLOW_OSC_TRIM_A == 4'h7 && O_OSCILLATOR_BIAS_CURRENT == 6'h11)
		else $error("decoded reset values wrong");
	a_div_four: assert property (div_ff == 3'h7 |-> O_REGULATOR_SWITCH_CLK != $past(O_REGULATOR_SWITCH_CLK, 2))
		else $error("regulator clock not divide by four");
	a_carrier_sum: assert property (up_ff == 3'h7 && $stable(O_CHANNEL_INDEX) |->
		O_CARRIER_WORD == CARRIER_WIDTH'(BASE_FREQ + O_CHANNEL_INDEX * CHANNEL_SPACING))
		else $error("carrier word wrong");
	a_quiet_hold: assert property (s_quiet |-> $stable(O_REGULATOR_ON) && $stable(O_CHANNEL_INDEX)
		&& $stable(O_RATE_MULTIPLIER_ON) && $stable(O_SLOW_OSC_TRIM_A))
		else $error("setting changed with no frame");
	a_tx_apply: assert property (!$past(I_RST) |-> O_TRANSMIT_OSC_CAL_APPLY == $past(I_TX_MODE))
		else $error("transmit apply not one cycle late");
	a_tx_word_idle: assert property (!O_TRANSMIT_OSC_CAL_APPLY |-> O_TRANSMIT_OSC_CAL_WORD == 7'h00)
		else $error("transmit word shown outside transmit");
	a_slow_gpio: assert property (s_gpio_sel |-> O_SLOW_CLK == $past(I_GPIO_SLOW_CLK))
		else $error("slow clock not from pin");
	a_slow_rc: assert property (s_rc_sel |-> O_SLOW_CLK == $past(I_SLOW_RC_CLK))
		else $error("slow clock not from rc oscillator");
endmodule

bind radio_cfg_regs radio_cfg_regs_props #(.CARRIER_WIDTH(CARRIER_WIDTH), .BASE_FREQ(BASE_FREQ),
	.CHANNEL_SPACING(CHANNEL_SPACING)) i_radio_cfg_regs_props (.*);
`default_nettype wire

// File: verification/cfg_host_model.sv
// Purpose: host controller on the serial port
// Assumes: mode 0, msb first, paced by I_CLK_SYS
// Notes: a frame is header, address and one data byte
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model
(
	// system clock
	input wire logic i_clk,
	// serial pins
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_mosi,
	input wire logic i_miso
);
	// idle pins at time zero
	initial
	begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end

	// one byte each way, sampled just before the rise
	task automatic xbyte(input logic [7:0] t, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			o_sclk <= 1'b0;
			o_mosi <= t[i];
			repeat (3) @(posedge i_clk);
			@(negedge i_clk);
			rx[i] = i_miso; // settled, away from the launching edge
			@(posedge i_clk);
			o_sclk <= 1'b1;
			repeat (2) @(posedge i_clk);
		end
	endtask

	// whole frame; the last byte read comes back
	task automatic access(input logic [7:0] h, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rx);
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		xbyte(h, rx);
		xbyte(a, rx);
		xbyte(d, rx);
		o_cs_n <= 1'b1;
		o_sclk <= 1'b0;
		o_mosi <= ~o_mosi; // no stale level out of frame
		@(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// File: verification/radio_cfg_regs_tb_top.sv
// Purpose: random test of the config register bank
// Assumes: host model frames of one data byte
// Notes: writes keep reserved bits as read back
`timescale 1ns/100ps
`default_nettype none
module radio_cfg_regs_tb_top;
	import radio_cfg_pkg::*;
	localparam logic [7:0] WMASK [REG_COUNT] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h6C, 8'hFF, 8'hFF, 8'h08, 8'h00, 8'h00};
	localparam logic [31:0] BASE = 32'h0001_0000;
	localparam logic [15:0] SPACING = 16'h0190;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rc = 1'b0;
	logic gp = 1'b0;
	logic tx = 1'b0;
	wire logic cs_n;
	wire logic sclk;
	wire logic mosi;
	logic miso, sw, rm, ron, vt, bw, tsb, ext, slow, apply;
	logic [3:0] trim_a;
	logic [4:0] trim_b;
	logic [7:0] chan, r;
	logic [31:0] car;
	logic [5:0] bias;
	logic [6:0] txw;
	logic [7:0] v [REG_COUNT];
	int n_mismatch = 0;
	int check_count = 0;
	int seed = 57;
	int c;
	int k;

	cfg_host_model i_cfg_host_model (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso));
	radio_cfg_regs #(.CARRIER_WIDTH(32), .BASE_FREQ(BASE), .CHANNEL_SPACING(SPACING)) i_radio_cfg_regs (
		.I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cs_n), .I_SCLK(sclk), .I_MOSI(mosi), .O_MISO(miso),
		.I_SLOW_RC_CLK(rc), .I_GPIO_SLOW_CLK(gp), .I_TX_MODE(tx), .O_REGULATOR_SWITCH_CLK(sw),
		.O_RATE_MULTIPLIER_ON(rm), .O_REGULATOR_ON(ron), .O_REGULATOR_TUNE_VOLTAGE(vt),
		.O_REGULATOR_LOOP_BANDWIDTH(bw), .O_TEMP_SENSE_BUFFER_ON(tsb), .O_EXTERNAL_SLOW_CLOCK(ext),
		.O_SLOW_CLK(slow), .O_SLOW_OSC_TRIM_A(trim_a), .O_SLOW_OSC_TRIM_B(trim_b), .O_CHANNEL_INDEX(chan),
		.O_CARRIER_WORD(car), .O_OSCILLATOR_BIAS_CURRENT(bias), .O_TRANSMIT_OSC_CAL_WORD(txw),
		.O_TRANSMIT_OSC_CAL_APPLY(apply));

	// clock and two unlike slow clock patterns
	always #50 clk = ~clk;
	always @(posedge clk) rc <= ~rc;
	always @(posedge clk) gp <= gp ^ rc;

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// count rises of the regulator clock over n edges
	task automatic count(input int n);
		logic p;
		p = sw;
		c = 0;
		repeat (n)
		begin
			@(negedge clk);
			if (sw === 1'b1 && p === 1'b0)
				c++;
			p = sw;
		end
	endtask

	// within one of the expected count
	function automatic logic near(input int a, input int b);
		return a >= b - 1 && a <= b + 1;
	endfunction

	// print counts and verdict, end the run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// main sequence
	initial
	begin
		for (int i = 0; i < REG_COUNT; i++)
			v[i] = REG_RESET[i];
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int p = 0; p < 4; p++)
		begin
			tx <= 1'($random(seed));
			repeat (3) @(posedge clk);
			@(negedge clk);
			chk(ron, !v[4][5]);
			chk(tsb, v[4][6]);
			chk({vt, bw}, v[4][3:2]);
			chk(rm, v[5][7]);
			chk(ext, v[7][3]);
			chk(trim_a, v[1][7:4]);
			chk(trim_b, {v[1][3:0], v[2][7]});
			chk(chan, v[0]);
			chk(car, BASE + v[0] * SPACING);
			chk(bias, v[3][5:0]);
			chk(apply, tx);
			chk(txw, tx ? v[2][6:0] : 7'h00);
			for (int i = 0; i < REG_COUNT; i++)
			begin
				i_cfg_host_model.access(HDR_READ, REG_ADDR[i], 8'h00, r);
				chk(r, v[i]);
				k = (p == 0) ? ~v[i] : $random(seed);
				v[i] = (k[7:0] & WMASK[i]) | (v[i] & ~WMASK[i]);
				i_cfg_host_model.access(HDR_WRITE, REG_ADDR[i], v[i], r);
			end
		end
		// unmapped read and a refused header
		i_cfg_host_model.access(HDR_READ, 8'h00, 8'h00, r);
		chk(r, UNMAPPED_READ);
		i_cfg_host_model.access(8'h02, REG_ADDR[0], ~v[0], r);
		i_cfg_host_model.access(HDR_READ, REG_ADDR[0], 8'h00, r);
		chk(r, v[0]);
		// rate multiplier, then the fixed divider
		// ratio below half scale, so the msb rises once per wrap
		k = 256 + ($random(seed) & 32'h3EFF);
		i_cfg_host_model.access(HDR_WRITE, REG_ADDR[6], k[7:0], r);
		i_cfg_host_model.access(HDR_WRITE, REG_ADDR[5], {1'b1, k[14:8]}, r);
		count(32768);
		chk(near(c, k), 1'b1);
		i_cfg_host_model.access(HDR_WRITE, REG_ADDR[5], 8'h00, r);
		count(400);
		chk(near(c, 100), 1'b1);
		stop_test();
	end

	// watchdog against a hung handshake
	initial
	begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
